// ==== rtl/outbound_translation_unit.sv ====
// Outbound translation stage: region match, address translation and transmit credit accounting.
// Assumes the client and the region configuration are on core_clk; one TLP accepted per enabled cycle.
`timescale 1ns/10ps
module outbound_translation_unit
#(
    parameter int ADDR_W = outbound_translation_pkg::ADDR_W,
    parameter int REGIONS = outbound_translation_pkg::REGIONS,
    parameter int CREDIT_W = outbound_translation_pkg::CREDIT_W
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Region configuration, flattened per region
    input wire logic [REGIONS-1:0] region_enable,
    input wire logic [REGIONS*ADDR_W-1:0] region_base,
    input wire logic [REGIONS*ADDR_W-1:0] region_limit,
    input wire logic [REGIONS*ADDR_W-1:0] region_target,
    input wire logic [REGIONS*2-1:0] region_credit_kind,
    // Outbound request from the client
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic [ADDR_W-1:0] req_client_addr,
    input wire logic [ADDR_W-1:0] req_header_addr,
    // Credit replenish pulses from the link side, one bit per credit kind
    input wire logic [2:0] credit_return,
    // Translated request
    output logic out_valid,
    output logic [1:0] out_kind,
    output logic [ADDR_W-1:0] out_addr,
    output logic out_translated,
    output logic [CREDIT_W-1:0] credit_posted,
    output logic [CREDIT_W-1:0] credit_nonposted,
    output logic [CREDIT_W-1:0] credit_cpl,
    output logic low_base_seen
);
    logic [REGIONS-1:0] hit;
    logic [ADDR_W-1:0] cmp_addr;
    logic any_hit;
    logic [ADDR_W-1:0] hit_base;
    logic [ADDR_W-1:0] hit_target;
    logic [1:0] hit_credit;
    logic low_base_now;
    logic next_out_valid;
    logic [1:0] next_out_kind;
    logic [ADDR_W-1:0] next_out_addr;
    logic next_out_translated;
    logic [CREDIT_W-1:0] next_credit_posted;
    logic [CREDIT_W-1:0] next_credit_nonposted;
    logic [CREDIT_W-1:0] next_credit_cpl;
    logic next_low_base_seen;

    // Messages are matched on header words three and four, everything else on the client address
    assign cmp_addr = (req_kind == outbound_translation_pkg::TLP_MESSAGE) ? req_header_addr : req_client_addr;

    // One comparator per region
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++)
        begin : g_region
            region_match #(.ADDR_W(ADDR_W)) u_match
            (
                .enable(region_enable[g]),
                .base(region_base[g*ADDR_W +: ADDR_W]),
                .limit(region_limit[g*ADDR_W +: ADDR_W]),
                .addr(cmp_addr),
                .hit(hit[g])
            );
        end
    endgenerate

    // Lowest-numbered hit wins; also flag any enabled region below the legal base
    always_comb
    begin
        any_hit = 1'b0;
        hit_base = '0;
        hit_target = '0;
        hit_credit = 2'h0;
        low_base_now = 1'b0;
        for (int i = REGIONS - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                any_hit = 1'b1;
                hit_base = region_base[i*ADDR_W +: ADDR_W];
                hit_target = region_target[i*ADDR_W +: ADDR_W];
                hit_credit = region_credit_kind[i*2 +: 2];
            end
            if (region_enable[i] && (region_base[i*ADDR_W +: ADDR_W] < outbound_translation_pkg::MIN_REGION_BASE))
            begin
                low_base_now = 1'b1;
            end
        end
    end

    // Next output and credit values
    always_comb
    begin
        next_out_valid = req_valid;
        next_out_kind = req_kind;
        next_out_addr = req_header_addr;
        next_out_translated = 1'b0;
        next_credit_posted = credit_posted + (credit_return[0] ? CREDIT_W'(1) : CREDIT_W'(0));
        next_credit_nonposted = credit_nonposted + (credit_return[1] ? CREDIT_W'(1) : CREDIT_W'(0));
        next_credit_cpl = credit_cpl + (credit_return[2] ? CREDIT_W'(1) : CREDIT_W'(0));
        next_low_base_seen = low_base_seen | low_base_now;
        if (req_valid)
        begin
            // Completions keep their address; others, messages included, are translated on a hit
            if (any_hit && (req_kind != outbound_translation_pkg::TLP_COMPLETION))
            begin
                next_out_addr = cmp_addr - hit_base + hit_target;
                next_out_translated = 1'b1;
            end
            // Credit of the hit region's type is taken, also for an untranslated completion
            if (any_hit)
            begin
                case (hit_credit)
                    outbound_translation_pkg::CREDIT_POSTED: next_credit_posted = next_credit_posted - CREDIT_W'(1);
                    outbound_translation_pkg::CREDIT_NONPOSTED:
                        next_credit_nonposted = next_credit_nonposted - CREDIT_W'(1);
                    outbound_translation_pkg::CREDIT_CPL: next_credit_cpl = next_credit_cpl - CREDIT_W'(1);
                    default: next_credit_cpl = next_credit_cpl;
                endcase
            end
        end
    end

    // Register everything; clock enable freezes state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_kind <= 2'h0;
            out_addr <= '0;
            out_translated <= 1'b0;
            credit_posted <= outbound_translation_pkg::CREDIT_RESET;
            credit_nonposted <= outbound_translation_pkg::CREDIT_RESET;
            credit_cpl <= outbound_translation_pkg::CREDIT_RESET;
            low_base_seen <= 1'b0;
        end
        else if (clk_en)
        begin
            out_valid <= next_out_valid;
            out_kind <= next_out_kind;
            out_addr <= next_out_addr;
            out_translated <= next_out_translated;
            credit_posted <= next_credit_posted;
            credit_nonposted <= next_credit_nonposted;
            credit_cpl <= next_credit_cpl;
            low_base_seen <= next_low_base_seen;
        end
    end

    // Completions never leave translated
    a_cpl_never_xlat: assert property (@(posedge core_clk) disable iff (!rst_n)
        out_valid && out_kind == outbound_translation_pkg::TLP_COMPLETION |-> !out_translated)
        else $error("completion translated");

    // A message hit produces a translated address one cycle later
    a_msg_hit_xlat: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && req_valid && req_kind == outbound_translation_pkg::TLP_MESSAGE && any_hit
        |=> out_translated && out_addr == $past(cmp_addr) - $past(hit_base) + $past(hit_target))
        else $error("message hit not translated");

    // Completion hitting a posted region with no return takes one posted credit
    a_cpl_credit_take: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && req_valid && req_kind == outbound_translation_pkg::TLP_COMPLETION && any_hit
        && hit_credit == outbound_translation_pkg::CREDIT_POSTED && credit_return == 3'h0
        |=> credit_posted == $past(credit_posted) - CREDIT_W'(1))
        else $error("completion credit not taken");

    // No hit and no return leaves every credit counter unchanged
    a_credit_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !(req_valid && any_hit) && credit_return == 3'h0
        |=> $stable(credit_posted) && $stable(credit_nonposted) && $stable(credit_cpl))
        else $error("credit moved without hit");

    // Disabled regions never hit
    a_region_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (hit & ~region_enable) == '0)
        else $error("disabled region hit");

    // Zero-based enabled region raises the sticky warning
    a_zero_base_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && low_base_now |=> low_base_seen)
        else $error("low base not flagged");

    // Completions leave with the header address untouched
    a_cpl_addr_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && req_valid && req_kind == outbound_translation_pkg::TLP_COMPLETION
        |=> !out_translated && out_addr == $past(req_header_addr))
        else $error("completion address changed");

    // Requests that miss every region pass through untranslated
    a_miss_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && req_valid && !any_hit
        |=> !out_translated && out_addr == $past(req_header_addr))
        else $error("missed request altered");

    // A request hitting a completion-credit region takes one such credit
    a_cpl_region_take: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && req_valid && any_hit && hit_credit == outbound_translation_pkg::CREDIT_CPL
        && credit_return == 3'h0
        |=> credit_cpl == $past(credit_cpl) - CREDIT_W'(1))
        else $error("region credit not taken");

    // A lone posted return adds one posted credit
    a_return_adds: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !req_valid && credit_return == 3'h1
        |=> credit_posted == $past(credit_posted) + CREDIT_W'(1))
        else $error("credit return lost");

    // Clock enable low freezes the outputs and the counters
    a_clk_en_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clk_en
        |=> $stable(out_valid) && $stable(out_addr) && $stable(out_translated) && $stable(credit_posted)
        && $stable(credit_nonposted) && $stable(credit_cpl))
        else $error("state moved while frozen");

    // The low-base warning stays set until reset
    a_low_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        low_base_seen |=> low_base_seen)
        else $error("low base warning dropped");
endmodule

// ==== rtl/outbound_translation_pkg.sv ====
// Package for the outbound translation stage: region table shape, TLP kinds, credit types.
// Assumes a single controller clock; regions are loaded from a flat configuration port.
package outbound_translation_pkg;
    localparam int ADDR_W = 64;
    localparam int REGIONS = 4;
    localparam int REGION_IDX_W = 2;
    localparam int CREDIT_W = 12;
    // Lowest base that the configuring party may use
    localparam logic [63:0] MIN_REGION_BASE = 64'h0000_0000_0000_1000;
    // Subsystem window size and its unusable bottom slice
    localparam logic [31:0] SUBSYS_WINDOW_SIZE = 32'h1000_0000;
    localparam logic [31:0] SUBSYS_GUARD_SIZE = 32'h0000_1000;
    // Reset value of each credit counter
    localparam logic [11:0] CREDIT_RESET = 12'h040;

    typedef enum logic [1:0]
    {
        TLP_MEMORY = 2'h0,
        TLP_MESSAGE = 2'h1,
        TLP_COMPLETION = 2'h2,
        TLP_OTHER = 2'h3
    } tlp_kind_type;

    typedef enum logic [1:0]
    {
        CREDIT_POSTED = 2'h0,
        CREDIT_NONPOSTED = 2'h1,
        CREDIT_CPL = 2'h2
    } credit_kind_type;
endpackage

// ==== rtl/region_match.sv ====
// One outbound region comparator: enable and inclusive base/limit window.
// Assumes base and limit are stable while the stage samples them.
`timescale 1ns/10ps
module region_match
#(
    parameter int ADDR_W = 64
)
(
    input wire logic enable,
    input wire logic [ADDR_W-1:0] base,
    input wire logic [ADDR_W-1:0] limit,
    input wire logic [ADDR_W-1:0] addr,
    output logic hit
);
    // Inclusive range compare, gated by the region enable
    assign hit = enable && (addr >= base) && (addr <= limit);
endmodule

// ==== verification/client_model.sv ====
// Client side of the outbound stage: turns bench commands into request signals.
// Assumes commands change just after a rising clock edge and hold for one cycle.
`timescale 1ns/10ps
module client_model
(
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic [63:0] cmd_addr,
    output logic req_valid,
    output logic [1:0] req_kind,
    output logic [63:0] req_client_addr,
    output logic [63:0] req_header_addr
);
    // Completions go out with the client address parked at zero; idle cycles show a changing pattern
    always_comb
    begin
        req_valid = cmd_valid;
        req_kind = cmd_kind;
        req_header_addr = cmd_addr;
        req_client_addr = (cmd_kind == outbound_translation_pkg::TLP_COMPLETION) ? 64'h0 : cmd_addr;
        if (!cmd_valid)
        begin
            req_header_addr = ~cmd_addr;
            req_client_addr = ~cmd_addr;
        end
    end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the outbound translation stage with a reference model.
// Assumes the default region count and the designer's one-cycle answer.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb;
    logic core_clk, rst_n, clk_en, cmd_valid, req_valid, out_valid, out_translated, low_base_seen, ev, etr, elow;
    logic [1:0] cmd_kind, req_kind, out_kind, ekind, ck[4];
    logic [2:0] credit_return;
    logic [3:0] en;
    logic [63:0] cmd_addr, req_client_addr, req_header_addr, out_addr, eaddr, a, base[4], lim[4], tgt[4];
    logic [11:0] credit_posted, credit_nonposted, credit_cpl;
    logic [31:0] r;
    int fails = 0, total_checks = 0, seed = 59316, h, cred[3];
    client_model i_client (.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .req_valid(req_valid),
        .req_kind(req_kind), .req_client_addr(req_client_addr), .req_header_addr(req_header_addr));
    outbound_translation_unit i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .region_enable(en),
        .region_base({base[3], base[2], base[1], base[0]}), .region_limit({lim[3], lim[2], lim[1], lim[0]}),
        .region_target({tgt[3], tgt[2], tgt[1], tgt[0]}), .region_credit_kind({ck[3], ck[2], ck[1], ck[0]}),
        .req_valid(req_valid), .req_kind(req_kind), .req_client_addr(req_client_addr),
        .req_header_addr(req_header_addr), .credit_return(credit_return), .out_valid(out_valid),
        .out_kind(out_kind), .out_addr(out_addr), .out_translated(out_translated), .credit_posted(credit_posted),
        .credit_nonposted(credit_nonposted), .credit_cpl(credit_cpl), .low_base_seen(low_base_seen));
    // Reference model: lowest matching region wins, completions never translate
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cred = '{64, 64, 64};
            ev = 0;
            elow = 0;
        end
        else if (clk_en)
        begin
            a = (req_kind == 2'h1) ? req_header_addr : req_client_addr;
            h = -1;
            for (int i = 3; i >= 0; i--) if (en[i] && a >= base[i] && a <= lim[i]) h = i;
            {ev, ekind, etr, eaddr} = {req_valid, req_kind, 1'b0, req_header_addr};
            if (req_valid && h >= 0)
            begin
                if (req_kind != 2'h2) {etr, eaddr} = {1'b1, a - base[h] + tgt[h]};
                if (ck[h] != 2'h3) cred[ck[h]]--;
            end
            for (int k = 0; k < 3; k++) cred[k] += credit_return[k];
            for (int i = 0; i < 4; i++) if (en[i] && base[i] < 64'h1000) elow = 1;
        end
    end
    // Compare on the falling edge, when registered outputs have settled
    always @(negedge core_clk)
    begin
        if (rst_n)
        begin
            `CHK("out_valid", ev, out_valid)
            if (ev)
            begin
                `CHK("out_kind", ekind, out_kind)
                `CHK("out_addr", eaddr, out_addr)
                `CHK("out_translated", etr, out_translated)
            end
            `CHK("credit_posted", 12'(cred[0]), credit_posted)
            `CHK("credit_nonposted", 12'(cred[1]), credit_nonposted)
            `CHK("credit_cpl", 12'(cred[2]), credit_cpl)
            `CHK("low_base_seen", elow, low_base_seen)
        end
    end
    task automatic run(input int n);
        logic [63:0] cand[8] = '{64'h0, 64'hfff, 64'h1000, 64'h1fff, 64'h2000, 64'hffff, 64'h1_0000, 64'h1_ffff};
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            r = $random(seed);
            cmd_valid = r[1:0] != 2'h0;
            cmd_kind = r[31] ? 2'h1 : r[3:2];
            cmd_addr = r[6] ? 64'h2000_1000 + {44'h0, r[27:8]} : cand[r[10:8]];
            clk_en = r[30:28] != 3'h0;
            credit_return = r[13:11];
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        {rst_n, clk_en, cmd_valid, cmd_kind, cmd_addr, credit_return} = '0;
        // Legal bases only, one region inside the reduced subsystem window
        base = '{64'h1000, 64'h1_0000, 64'h2000_1000, 64'h0};
        lim = '{64'h1fff, 64'h1_ffff, 64'h2fff_ffff, 64'hfff};
        tgt = '{64'h8000_0000, 64'h9000_0000, 64'h4_0000_0000, 64'h7000_0000};
        ck = '{2'h0, 2'h1, 2'h2, 2'h0};
        en = 4'h7;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1;
        run(300);
        // Deliberately enable a zero-based region to expose the hazard
        en = 4'hf;
        run(150);
        @(posedge core_clk);
        #1 rst_n = 0;
        en = 4'h7;
        // A region that takes no credit on a hit
        ck[1] = 2'h3;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1;
        run(50);
        tally_and_finish();
    end
endmodule
